// ===== hdl/sbs_sram.sv
// synchronous pipelined burst sram with common data pins
`timescale 1ns/1ps
module sbs_sram (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [sbs_pkg::ADDR_W-1:0] addr_in,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic chip_sel_first_n,
   input wire logic chip_sel_second,
   input wire logic chip_sel_third_n,
   input wire logic all_bytes_write_n,
   input wire logic byte_write_qualify_n,
   input wire logic lane0_write_sel_n,
   input wire logic lane1_write_sel_n,
   input wire logic lane2_write_sel_n,
   input wire logic lane3_write_sel_n,
   input wire logic burst_advance_n,
   input wire logic output_enable_n,
   input wire logic burst_order,
   input wire logic sleep_request,
   input wire logic [sbs_pkg::WORD_W-1:0] data_in,
   output logic [sbs_pkg::WORD_W-1:0] data_out,
   output logic [sbs_pkg::WORD_W-1:0] data_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts once stages two and three agree
   localparam int NSYNC = 3;
   logic [NSYNC-1:0] oe_sync_r, ord_sync_r, zz_sync_r;
   logic oe_n_r, ord_r, zz_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         oe_sync_r <= 3'h7;
         ord_sync_r <= 3'h7;
         zz_sync_r <= 3'h0;
         oe_n_r <= 1'b1;
         ord_r <= 1'b1;
         zz_r <= 1'b0;
      end else begin
         oe_sync_r <= {oe_sync_r[1:0], output_enable_n};
         ord_sync_r <= {ord_sync_r[1:0], burst_order};
         zz_sync_r <= {zz_sync_r[1:0], sleep_request};
         if (oe_sync_r[1] == oe_sync_r[2]) begin
            oe_n_r <= oe_sync_r[2];
         end
         if (ord_sync_r[1] == ord_sync_r[2]) begin
            ord_r <= ord_sync_r[2];
         end
         if (zz_sync_r[1] == zz_sync_r[2]) begin
            zz_r <= zz_sync_r[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronous input register
   sbs_pkg::sbs_in_s in_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_r <= '0;
      end else begin
         in_r.proc_strobe <= ~proc_addr_strobe_n;
         in_r.ctrl_strobe <= ~ctrl_addr_strobe_n;
         in_r.sel <= ~chip_sel_first_n & chip_sel_second & ~chip_sel_third_n;
         in_r.first_sel <= ~chip_sel_first_n;
         in_r.all_wr <= ~all_bytes_write_n;
         in_r.byte_q <= ~byte_write_qualify_n;
         in_r.lane_sel <= ~{lane3_write_sel_n, lane2_write_sel_n, lane1_write_sel_n, lane0_write_sel_n};
         in_r.advance <= ~burst_advance_n;
         in_r.addr <= addr_in;
         in_r.wdata <= data_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] sbs_beat(input logic [1:0] start, input logic [1:0] count, input logic lin);
      // linear wraps inside the four-beat group, interleaved is xor
      sbs_beat = lin ? 2'(start + count) : (start ^ count);
   endfunction

   function automatic logic [sbs_pkg::LANES-1:0] sbs_lanes(input sbs_pkg::sbs_in_s i);
      if (i.all_wr) begin
         sbs_lanes = '1;
      end else if (i.byte_q) begin
         sbs_lanes = i.lane_sel;
      end else begin
         sbs_lanes = '0;
      end
   endfunction

   logic [sbs_pkg::WORD_W-1:0] mem_r [sbs_pkg::DEPTH];
   sbs_pkg::sbs_state_s st_r, st_nxt;
   logic [sbs_pkg::LANES-1:0] we;
   logic [sbs_pkg::ADDR_W-1:0] wr_addr, rd_addr;
   logic ps_take, cs_take, dsel, wr_any, lin;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      we = '0;
      lin = ~ord_r;
      wr_any = in_r.all_wr | (in_r.byte_q & |in_r.lane_sel);
      // processor strobe needs first select low; it beats the controller strobe
      ps_take = in_r.proc_strobe & in_r.first_sel;
      cs_take = in_r.ctrl_strobe & ~ps_take;
      dsel = (ps_take | in_r.ctrl_strobe) & ~in_r.sel;
      wr_addr = {st_r.addr[sbs_pkg::ADDR_W-1:2], sbs_beat(st_r.start, st_r.count, lin)};
      rd_addr = wr_addr;
      st_nxt.rvalid = 1'b0;
      st_nxt.float_next = 1'b0;
      // sleep freezes the port; array contents untouched
      if (!zz_r) begin
         if ((ps_take | cs_take) & in_r.sel) begin
            st_nxt.addr = in_r.addr;
            st_nxt.start = in_r.addr[1:0];
            st_nxt.count = sbs_pkg::BURST_RST;
            rd_addr = in_r.addr;
            if (ps_take) begin
               // write controls ignored on this edge
               st_nxt.op = sbs_pkg::SBS_PWRITE;
               st_nxt.rvalid = 1'b1;
            end else if (wr_any) begin
               st_nxt.op = sbs_pkg::SBS_WRITE;
               we = sbs_lanes(in_r);
               wr_addr = in_r.addr;
            end else begin
               st_nxt.op = sbs_pkg::SBS_READ;
               st_nxt.rvalid = 1'b1;
            end
            st_nxt.first_mask = ~st_r.sel_prev;
            st_nxt.sel_prev = 1'b1;
         end else if (dsel) begin
            st_nxt.op = sbs_pkg::SBS_IDLE;
            st_nxt.sel_prev = 1'b0;
            st_nxt.float_next = 1'b1;
         end else begin
            case (st_r.op)
               sbs_pkg::SBS_IDLE: begin
                  st_nxt.first_mask = 1'b0;
               end
               sbs_pkg::SBS_READ, sbs_pkg::SBS_PWRITE, sbs_pkg::SBS_WRITE: begin
                  st_nxt.first_mask = 1'b0;
                  if (wr_any) begin
                     we = sbs_lanes(in_r);
                     st_nxt.op = sbs_pkg::SBS_WRITE;
                  end else begin
                     st_nxt.op = sbs_pkg::SBS_READ;
                  end
                  if (in_r.advance) begin
                     st_nxt.count = 2'(st_r.count + 2'h1);
                     if (!wr_any) begin
                        rd_addr = {st_r.addr[sbs_pkg::ADDR_W-1:2], sbs_beat(st_r.start, st_nxt.count, lin)};
                        st_nxt.rvalid = 1'b1;
                     end
                  end else if (!wr_any) begin
                     st_nxt.rvalid = 1'b1;
                  end
               end
               default: begin
                  st_nxt.op = sbs_pkg::SBS_IDLE;
               end
            endcase
         end
         if (st_nxt.rvalid) begin
            st_nxt.rdata = mem_r[rd_addr];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk) begin
      for (int l = 0; l < sbs_pkg::LANES; l++) begin
         if (we[l]) begin
            mem_r[wr_addr][l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] <= in_r.wdata[l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive; output enable is resampled so oe_n_r lags the pin by four edges, one past the sync depth
   logic drive;
   assign drive = ~oe_n_r & st_r.rvalid & ~st_r.first_mask & (st_r.op != sbs_pkg::SBS_WRITE)
                  & ~st_r.float_next & ~zz_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_out <= sbs_pkg::WORD_RST;
         data_oe <= '0;
      end else begin
         data_out <= st_r.rdata;
         data_oe <= {sbs_pkg::WORD_W{drive}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence sel_take_s;
      (ps_take | cs_take) & in_r.sel & ~zz_r;
   endsequence
   sequence burst_adv_s;
      ~zz_r & ~dsel & ~ps_take & ~cs_take & in_r.advance & (st_r.op != sbs_pkg::SBS_IDLE);
   endsequence
   // processor write: strobe edge, then a plain cycle carrying the write controls
   sequence ps_write_s;
      (ps_take & in_r.sel & ~zz_r) ##1 (~zz_r & ~dsel & ~ps_take & ~cs_take & wr_any);
   endsequence

   // address capture and burst counter
   addr_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
      sel_take_s |=> st_r.addr == $past(in_r.addr))
      else $error("address not captured");

   counter_seed_a: assert property (@(posedge clk) disable iff (sys_rst)
      sel_take_s |=> st_r.count == 2'h0 && st_r.start == $past(in_r.addr[1:0]))
      else $error("burst counter not seeded");

   burst_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      burst_adv_s |=> st_r.count == 2'($past(st_r.count) + 2'h1))
      else $error("burst did not advance");

   beat_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
      burst_adv_s ##0 (st_r.count == 2'h3) |=> st_r.count == 2'h0)
      else $error("burst counter did not wrap");

   ilv_order_a: assert property (@(posedge clk) disable iff (sys_rst)
      burst_adv_s ##0 (~wr_any & ~lin) |-> rd_addr[1:0] == (st_r.start ^ 2'(st_r.count + 2'h1)))
      else $error("interleaved beat address wrong");

   lin_order_a: assert property (@(posedge clk) disable iff (sys_rst)
      burst_adv_s ##0 (~wr_any & lin) |-> rd_addr[1:0] == 2'(st_r.start + st_r.count + 2'h1))
      else $error("linear beat address wrong");

   // strobes and chip selects
   proc_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
      in_r.proc_strobe & ~in_r.first_sel & ~in_r.ctrl_strobe & ~zz_r |=> $stable(st_r.addr) && $stable(st_r.sel_prev))
      else $error("processor strobe taken while first select high");

   strobe_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
      in_r.proc_strobe & in_r.first_sel & in_r.sel & ~zz_r |=> st_r.op == sbs_pkg::SBS_PWRITE)
      else $error("processor strobe lost priority");

   both_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
      in_r.proc_strobe & in_r.ctrl_strobe & in_r.first_sel & in_r.sel & ~zz_r |-> we == 4'h0)
      else $error("controller strobe write acted on with both strobes");

   part_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
      in_r.ctrl_strobe & ~in_r.sel & ~zz_r |=> st_r.op == sbs_pkg::SBS_IDLE && !st_r.sel_prev)
      else $error("selected without all chip selects");

   // write lanes
   all_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      |we & in_r.all_wr |-> we == 4'hF)
      else $error("all-byte write missed a lane");

   lane_qual_a: assert property (@(posedge clk) disable iff (sys_rst)
      ~in_r.all_wr & ~in_r.byte_q |-> we == 4'h0)
      else $error("lane written without qualifier");

   lane_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
      ~in_r.all_wr & in_r.byte_q & |we |-> we == in_r.lane_sel)
      else $error("byte write hit an unselected lane");

   ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      cs_take & in_r.sel & ~zz_r & wr_any |-> wr_addr == in_r.addr && we == (in_r.all_wr ? 4'hF : in_r.lane_sel))
      else $error("controller write not done in its strobe cycle");

   pwrite_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      ps_take & in_r.sel & ~zz_r |-> we == 4'h0)
      else $error("write controls used on processor strobe edge");

   pwrite_second_a: assert property (@(posedge clk) disable iff (sys_rst)
      ps_write_s |-> wr_addr == st_r.addr && we == (in_r.all_wr ? 4'hF : in_r.lane_sel))
      else $error("processor write not done on second edge");

   // read path and pin drive
   read_take_a: assert property (@(posedge clk) disable iff (sys_rst)
      (ps_take | cs_take & ~wr_any) & in_r.sel & ~zz_r |=> st_r.rvalid)
      else $error("read data not loaded after address capture");

   first_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      sel_take_s ##0 ~st_r.sel_prev |=> st_r.first_mask)
      else $error("first cycle after deselect not masked");

   first_float_a: assert property (@(posedge clk) disable iff (sys_rst)
      sel_take_s & ~st_r.sel_prev |=> ##1 data_oe == '0)
      else $error("drove in first cycle after deselect");

   write_float_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_r.op == sbs_pkg::SBS_WRITE |=> data_oe == '0)
      else $error("drove during write");

   desel_float_a: assert property (@(posedge clk) disable iff (sys_rst)
      dsel & ~zz_r |=> ##1 data_oe == '0)
      else $error("drove after deselect");

   sleep_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      zz_r |-> we == '0 ##1 $stable(st_r.addr))
      else $error("activity during sleep");

   sleep_dark_a: assert property (@(posedge clk) disable iff (sys_rst)
      zz_r |=> data_oe == '0)
      else $error("drove during sleep");

   oe_float_a: assert property (@(posedge clk) disable iff (sys_rst)
      oe_n_r |=> data_oe == '0)
      else $error("drove with output enable high");
endmodule

// ===== hdl/sbs_pkg.sv
// constants and carrier types for the synchronous burst sram pin block
// How it works
// - address taken when a strobe is low and all chip selects are active
// - low two address bits seed the two-bit burst counter
// - a lane select writes its lane only with the byte write qualifier low
// - all-byte write low writes every lane, ignoring selects and qualifier
// - advance low during a burst steps the burst address
// - processor strobe ignored while first chip select is high
// - selected only when all three chip selects are active
// - output enable low drives data pins, high floats them
// - first read cycle after deselect keeps outputs floating
// - controller strobe loads full address and the burst counter
// - both strobes low: only the processor strobe is acted on
// - order strap low gives linear order, high gives interleaved
// - sleep input stops activity while keeping memory contents
// - write data captured into an input register on the clock edge
// - read data leaves output registers one clock after address capture
// - four lanes of eight data bits plus one parity bit each
// - data pins float whenever a write cycle is detected
// - processor strobe write takes two clocks, controls on second edge
// - controller strobe write completes in one clock
// - outputs float after the edge following a deselect
package sbs_pkg;
   localparam int ADDR_W = 10;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = LANES * LANE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam logic [1:0] BURST_RST = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = '0;
   localparam logic [WORD_W-1:0] WORD_RST = '0;

   typedef struct packed {
      logic proc_strobe;
      logic ctrl_strobe;
      logic sel;
      logic first_sel;
      logic all_wr;
      logic byte_q;
      logic [LANES-1:0] lane_sel;
      logic advance;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } sbs_in_s;

   typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_PWRITE, SBS_WRITE} sbs_op_e;

   typedef struct packed {
      sbs_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [1:0] start;
      logic [1:0] count;
      logic [WORD_W-1:0] rdata;
      logic rvalid;
      logic sel_prev;
      logic first_mask;
      logic float_next;
   } sbs_state_s;
endpackage

// ===== test/sbs_host.sv
// controller model driving the pins of the burst sram block
`timescale 1ns/1ps
module sbs_host (
   input wire logic clk,
   output logic [sbs_pkg::ADDR_W-1:0] addr_in,
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic chip_sel_first_n,
   output logic all_bytes_write_n,
   output logic byte_write_qualify_n,
   output logic [3:0] lane_sel_n,
   output logic burst_advance_n,
   output logic output_enable_n,
   output logic burst_order,
   output logic sleep_request,
   output logic [sbs_pkg::WORD_W-1:0] data_in
);
   task automatic set(input logic p, c, f, g, q, input logic [3:0] l, input logic a,
      input logic [sbs_pkg::ADDR_W-1:0] ad, input logic [sbs_pkg::WORD_W-1:0] d);
      proc_addr_strobe_n = p;
      ctrl_addr_strobe_n = c;
      chip_sel_first_n = f;
      all_bytes_write_n = g;
      byte_write_qualify_n = q;
      lane_sel_n = l;
      burst_advance_n = a;
      addr_in = ad;
      // released bus flips every cycle so stale data never looks valid
      data_in = (g & q) ? ~data_in : d;
   endtask
   task automatic step(input logic p, c, f, g, q, input logic [3:0] l, input logic a,
      input logic [sbs_pkg::ADDR_W-1:0] ad, input logic [sbs_pkg::WORD_W-1:0] d);
      @(posedge clk);
      #1;
      set(p, c, f, g, q, l, a, ad, d);
   endtask
   // only called between accesses, so the strap never moves mid-burst
   task automatic misc(input logic oe, o, z);
      @(posedge clk);
      #1;
      output_enable_n = oe;
      burst_order = o;
      sleep_request = z;
   endtask
   initial begin
      data_in = '0;
      output_enable_n = 1'b1;
      burst_order = 1'b1;
      sleep_request = 1'b0;
      set(1, 1, 0, 1, 1, 4'hF, 1, '0, '0);
   end
endmodule

// ===== test/sync_burst_sram_pin_protocol_test.sv
// self-checking bench for the burst sram pin block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module sync_burst_sram_pin_protocol_test;
   localparam int W = sbs_pkg::WORD_W;
   localparam int AW = sbs_pkg::ADDR_W;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [AW-1:0] addr_in;
   logic ps_n, cs_n, f_n, g_n, q_n, adv_n, oe_n, ord, slp;
   logic [3:0] l_n;
   logic sel2 = 1'b1;
   logic sel3_n = 1'b0;
   logic [W-1:0] din, dout, doe, old;
   logic [W-1:0] mem [0:3];
   int error_cnt = 0;
   int cmp_count = 0;
   always #50 clk = ~clk;
   sbs_host i_host (.clk(clk), .addr_in(addr_in), .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n),
      .chip_sel_first_n(f_n), .all_bytes_write_n(g_n), .byte_write_qualify_n(q_n), .lane_sel_n(l_n),
      .burst_advance_n(adv_n), .output_enable_n(oe_n), .burst_order(ord), .sleep_request(slp), .data_in(din));
   sbs_sram i_dut (.clk(clk), .sys_rst(sys_rst), .addr_in(addr_in), .proc_addr_strobe_n(ps_n),
      .ctrl_addr_strobe_n(cs_n), .chip_sel_first_n(f_n), .chip_sel_second(sel2), .chip_sel_third_n(sel3_n),
      .all_bytes_write_n(g_n), .byte_write_qualify_n(q_n), .lane0_write_sel_n(l_n[0]),
      .lane1_write_sel_n(l_n[1]), .lane2_write_sel_n(l_n[2]), .lane3_write_sel_n(l_n[3]),
      .burst_advance_n(adv_n), .output_enable_n(oe_n), .burst_order(ord), .sleep_request(slp),
      .data_in(din), .data_out(dout), .data_oe(doe));
   task automatic tally_and_finish;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) i_host.step(1, 1, 0, 1, 1, 4'hF, 1, '0, '0);
   endtask
   // controller-strobe write, one clock; bench memory follows the lane rules
   task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d, input logic g, q, input logic [3:0] l);
      i_host.step(1, 0, 0, g, q, l, 1, a, d);
      for (int i = 0; i < 4; i++) begin
         if (!g || (!q && !l[i])) begin
            mem[a[1:0]][9*i+:9] = d[9*i+:9];
         end
      end
      idle(2);
   endtask
   // burst read of n beats; fo is the expected first-beat enable
   task automatic rd(input logic [AW-1:0] a, input int n, input logic fo);
      logic [1:0] k;
      logic e;
      i_host.step(1, 0, 0, 1, 1, 4'hF, 1, a, '0);
      // beat b stands on the pins just after the edge three past the strobe edge plus b
      for (int i = 1; i < n + 3; i++) begin
         i_host.step(1, 1, 0, 1, 1, 4'hF, (i < n) ? 1'b0 : 1'b1, '0, '0);
         if (i >= 3) begin
            k = ord ? a[1:0] ^ 2'(i - 3) : a[1:0] + 2'(i - 3);
            e = (i == 3) ? fo & ~oe_n : ~oe_n;
            `CHK("rdata", mem[k], dout)
            `CHK("oe", {W{e}}, doe)
         end
      end
   endtask
   // deselect through the second, then the third select
   task automatic t_chips;
      for (int s = 0; s < 2; s++) begin
         i_host.step(1, 0, 0, 1, 1, 4'hF, 1, 0, '0);
         sel2 = (s == 1);
         sel3_n = (s == 1);
         idle(1);
         sel2 = 1'b1;
         sel3_n = 1'b0;
         idle(2);
         `CHK("chip float", {W{1'b0}}, doe)
         rd(2, 1, 0);
      end
   endtask
   task automatic t_order;
      rd(1, 4, 1);
      i_host.misc(0, 1, 0);
      idle(2);
      rd(1, 4, 1);
   endtask
   task automatic t_bytes;
      wr(2, 36'h1_2345_6789, 1, 0, 4'hA);
      wr(3, 36'hF_FFFF_FFFF, 1, 1, 4'h0);
      rd(2, 2, 1);
   endtask
   task automatic t_proc;
      // write controls on the strobe edge must be ignored
      i_host.step(0, 1, 0, 0, 1, 4'hF, 1, 1, 36'h0_0000_0000);
      i_host.step(1, 1, 0, 1, 0, 4'hE, 1, 1, 36'h9_8765_4321);
      mem[1][8:0] = 9'h121;
      idle(2);
      rd(1, 1, 1);
   endtask
   task automatic t_both;
      i_host.step(0, 0, 0, 0, 1, 4'hF, 1, 0, 36'hA_AAAA_AAAA);
      idle(3);
      rd(0, 1, 1);
   endtask
   task automatic t_desel;
      rd(3, 1, 1);
      i_host.step(1, 0, 1, 1, 1, 4'hF, 1, 0, '0);
      idle(3);
      `CHK("float", {W{1'b0}}, doe)
      rd(3, 2, 0);
      i_host.step(0, 1, 1, 1, 1, 4'hF, 1, 0, '0);
      idle(2);
      rd(3, 1, 1);
   endtask
   task automatic t_oe_sleep;
      i_host.misc(1, ord, 0);
      idle(4);
      rd(0, 2, 1);
      i_host.misc(0, ord, 1);
      idle(4);
      old = mem[3];
      wr(3, '0, 0, 1, 4'hF);
      mem[3] = old;
      i_host.misc(0, ord, 0);
      idle(4);
      rd(3, 1, 1);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      i_host.misc(0, 0, 0);
      idle(4);
      for (int i = 0; i < 4; i++) begin
         wr(AW'(i), {4{9'h0C3 ^ 9'(i * 37)}}, 0, 1, 4'hF);
      end
      t_order();
      t_bytes();
      t_proc();
      t_both();
      t_desel();
      t_chips();
      t_oe_sleep();
      tally_and_finish();
   end
endmodule
